// ---- hdl/pwm_timer_dead_time_capture.sv ----
// pwm_timer_dead_time_capture: 12-bit pwm timer with dead-time bridge
// outputs, converter strobe and input capture, apb register access.
// assumes pclk at 100 MHz; pin inputs and straps are asynchronous.
`timescale 1ns/1ns
`default_nettype none

module pwm_timer_dead_time_capture (
    // clock, reset, enable
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // pins and straps
    input  wire logic                  low_side_out_capture_in,
    input  wire logic [1:0]            init_polarity,
    input  wire logic [1:0]            init_output,
    input  wire logic                  comparator_shutdown,
    output pwm_pkg::bridge_pins_t      pins,
    // events
    output logic                       converter_start,
    output logic                       timer_irq
);

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    pwm_pkg::timer_state_t s;
    pwm_pkg::timer_state_t n;

    logic       capture;
    logic       hs_en;
    logic       ls_en;
    logic       tick;
    logic [6:0] div_max;
    logic       cap_edge;
    logic       access;
    logic       wr_done;
    logic       wr_ctrl;
    logic       pend_evt;
    logic       shut_now;
    logic       mapped;
    logic [31:0] rd_val;

    // mode bits: 1xx is capture, bit 0 enables high side in every mode
    assign capture  = s.mode[2];
    assign hs_en    = s.mode[0];
    assign ls_en    = s.mode[1] & ~s.mode[2];
    // divider runs on pclk; only the counter, its compares and the capture sample see the tick
    assign div_max  = 7'((8'h01 << s.prescale[2:0]) - 8'h01);
    assign tick     = (s.div_cnt == div_max);
    // edge taken against the previous tick's sample of the synced pin
    assign cap_edge = s.mode[1] ? (s.cap_prev & ~s.sync2[0])
                                : (~s.cap_prev & s.sync2[0]);
    assign access   = psel & penable;
    assign wr_done  = access & s.pready & pwrite & ~s.pslverr;
    assign wr_ctrl  = wr_done & (paddr == pwm_pkg::OFF_CTRL);
    assign shut_now = s.shut[pwm_pkg::SHUT_EN] & comparator_shutdown;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            pwm_pkg::OFF_CTRL:     rd_val[7:0] = {s.mode,
                                       capture ? s.ovf : s.run_act,
                                       s.pend, s.irq_en, 1'b0, s.route};
            pwm_pkg::OFF_PERIOD:   rd_val[11:0] = s.period;
            pwm_pkg::OFF_CMPA:     rd_val[11:0] = s.cmpa;
            pwm_pkg::OFF_CMPB:     rd_val[11:0] = s.cmpb;
            pwm_pkg::OFF_DEAD:     rd_val[4:0]  = s.dead;
            pwm_pkg::OFF_PRESCALE: rd_val[7:0]  = s.prescale;
            pwm_pkg::OFF_PDATA:    rd_val[7:0]  = s.pdata;
            pwm_pkg::OFF_PCFG:     rd_val[7:0]  = s.pcfg;
            pwm_pkg::OFF_CONV:     rd_val[7:0]  = s.conv;
            pwm_pkg::OFF_SHUT:     rd_val[1:0]  = s.shut;
            pwm_pkg::OFF_COUNT:    rd_val[11:0] = s.cnt;
            default:               mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n            = s;
        n.conv_start = 1'b0;
        pend_evt     = 1'b0;

        // pin synchronisers, first stage read only by the second
        n.sync1 = {init_output, init_polarity, low_side_out_capture_in};
        n.sync2 = s.sync1;

        // straps load once both synchroniser stages hold real values
        if (s.init_cnt != pwm_pkg::INIT_DONE) begin
            n.init_cnt = s.init_cnt + 2'h1;
        end
        if (s.init_cnt == pwm_pkg::INIT_LOAD) begin
            n.pdata[pwm_pkg::HS_POL] = s.sync2[1];
            n.pdata[pwm_pkg::LS_POL] = s.sync2[2];
            n.pcfg[pwm_pkg::HS_POL]  = s.sync2[3];
            n.pcfg[pwm_pkg::LS_POL]  = s.sync2[4];
        end

        // apb: one wait state, answer registered, write at completion
        if (access & ~s.pready) begin
            n.pready  = 1'b1;
            n.pslverr = ~mapped;
            n.prdata  = rd_val;
        end else begin
            n.pready  = 1'b0;
            n.pslverr = 1'b0;
        end
        if (wr_done) begin
            case (paddr)
                pwm_pkg::OFF_CTRL: begin
                    n.mode   = pwdata[pwm_pkg::MODE_LSB +: 3];
                    n.irq_en = pwdata[pwm_pkg::IRQEN_BIT];
                    n.route  = pwdata[pwm_pkg::ROUTE_BIT];
                    if (capture) begin
                        // bit 4 is the overflow flag here: 0 clears
                        if (!pwdata[pwm_pkg::RUN_BIT]) n.ovf = 1'b0;
                    end else begin
                        n.run_req = pwdata[pwm_pkg::RUN_BIT];
                    end
                    if (!pwdata[pwm_pkg::PEND_BIT]) n.pend = 1'b0;
                end
                pwm_pkg::OFF_PERIOD:   n.period   = pwdata[11:0];
                pwm_pkg::OFF_CMPA:     n.cmpa     = pwdata[11:0];
                pwm_pkg::OFF_CMPB:     n.cmpb     = pwdata[11:0];
                pwm_pkg::OFF_DEAD:     n.dead     = pwdata[4:0];
                pwm_pkg::OFF_PRESCALE: n.prescale = pwdata[7:0];
                pwm_pkg::OFF_PDATA:    n.pdata    = pwdata[7:0];
                pwm_pkg::OFF_PCFG:     n.pcfg     = pwdata[7:0];
                pwm_pkg::OFF_CONV:     n.conv     = pwdata[7:0];
                pwm_pkg::OFF_SHUT:     n.shut     = pwdata[1:0];
                default:               n.shut     = s.shut;
            endcase
        end

        // dead-time counter runs on pclk, so the prescaler never stretches it
        if (s.lead_pend) begin
            if (s.dt_cnt == 5'h00) begin
                n.lead_pend = 1'b0;
                n.ls_act    = ~s.killed;
            end else begin
                n.dt_cnt = s.dt_cnt - 5'h01;
            end
        end

        // timer sequencing; hardware sets land after writes so sets win
        case (s.phase)
            pwm_pkg::PH_IDLE: begin
                n.cnt     = pwm_pkg::CNT_ZERO;
                n.div_cnt = 7'h00;
                n.hs_act  = 1'b0;
                n.ls_act  = 1'b0;
                n.sb_act  = 1'b0;
                if (capture || s.run_req) begin
                    n.phase   = pwm_pkg::PH_RUN;
                    n.run_act = ~capture;
                end
            end
            pwm_pkg::PH_RUN: begin
                n.div_cnt = tick ? 7'h00 : s.div_cnt + 7'h01;
                if (tick) begin
                    n.cap_prev = s.sync2[0];
                    if (capture) begin
                        if (cap_edge) begin
                            n.period = s.cnt;
                            n.pend   = 1'b1;
                            pend_evt = 1'b1;
                        end
                        if (s.cnt == pwm_pkg::CNT_MAX) begin
                            n.cnt    = pwm_pkg::CNT_ZERO;
                            n.ovf    = 1'b1;
                            n.hs_act = 1'b0;
                            n.sb_act = 1'b0;
                        end else begin
                            n.cnt = s.cnt + 12'h001;
                        end
                    end else if (s.cnt == s.period) begin
                        // low side rests now, high side after dead time
                        n.cnt       = pwm_pkg::CNT_ZERO;
                        n.pend      = 1'b1;
                        pend_evt    = 1'b1;
                        n.ls_act    = 1'b0;
                        n.sb_act    = 1'b0;
                        n.lead_pend = 1'b0;
                        n.dt_cnt    = s.dead;
                        n.phase     = pwm_pkg::PH_TAIL;
                    end else begin
                        n.cnt = s.cnt + 12'h001;
                    end
                    // compare matches on the count held before this tick's increment
                    if (s.cnt == s.cmpa && !s.killed &&
                        n.phase == pwm_pkg::PH_RUN) begin
                        n.hs_act = 1'b1;
                        if (!capture) begin
                            n.lead_pend = 1'b1;
                            n.dt_cnt    = s.dead;
                        end
                    end
                    if (s.cnt == s.cmpb && n.phase == pwm_pkg::PH_RUN) begin
                        n.sb_act = 1'b1;
                    end
                end
                // leaving capture for pwm with run clear stops at once
                if (capture && !n.mode[2] && !s.run_req) begin
                    n.phase = pwm_pkg::PH_IDLE;
                end
            end
            pwm_pkg::PH_TAIL: begin
                // counted on pclk even when both bridge outputs are disabled
                if (s.dt_cnt == 5'h00) begin
                    n.hs_act = 1'b0;
                    n.killed = 1'b0;
                    if (s.run_req || capture) begin
                        n.phase = pwm_pkg::PH_RUN;
                    end else begin
                        n.phase   = pwm_pkg::PH_IDLE;
                        n.run_act = 1'b0;
                    end
                end else begin
                    n.dt_cnt = s.dt_cnt - 5'h01;
                end
            end
            default: n.phase = pwm_pkg::PH_IDLE;
        endcase

        // comparator shutdown: kill this cycle or stop everything
        if (shut_now) begin
            n.hs_act    = 1'b0;
            n.ls_act    = 1'b0;
            n.lead_pend = 1'b0;
            n.killed    = 1'b1;
            if (s.shut[pwm_pkg::SHUT_ALL]) begin
                n.run_req = 1'b0;
                n.run_act = 1'b0;
                n.killed  = 1'b0;
                n.phase   = pwm_pkg::PH_IDLE;
            end
        end

        // registered pins: polarity by xor, direction from port config
        n.pins.high_side_out = (s.hs_act & hs_en) ^ s.pdata[pwm_pkg::HS_POL];
        n.pins.high_side_oe  = s.pcfg[pwm_pkg::HS_POL];
        n.pins.low_side_out  = (s.ls_act & ls_en) ^ s.pdata[pwm_pkg::LS_POL];
        n.pins.low_side_oe   = s.pcfg[pwm_pkg::LS_POL] & ~capture;
        n.pins.converter_strobe    = s.sb_act ^ s.pdata[pwm_pkg::SB_POL];
        n.pins.converter_strobe_oe = s.pcfg[pwm_pkg::SB_POL] & s.route;
        // conversion kick on the strobe's rest-to-active edge
        n.conv_start = n.sb_act & ~s.sb_act & s.conv[pwm_pkg::AUTO_BIT];
        // interrupt request follows the flags of the current mode
        n.irq = s.irq_en & (s.pend | (capture & s.ovf));
    end

    // ------------------------------------------------------------
    // state register, frozen while ce is low
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    assign prdata          = s.prdata;
    assign pready          = s.pready;
    assign pslverr         = s.pslverr;
    assign pins            = s.pins;
    assign converter_start = s.conv_start;
    assign timer_irq       = s.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence period_hit;
        ce && tick && s.phase == pwm_pkg::PH_RUN && !capture
            && s.cnt == s.period && !shut_now;
    endsequence

    sequence tail_entered;
        s.phase == pwm_pkg::PH_TAIL && s.cnt == pwm_pkg::CNT_ZERO && s.pend;
    endsequence

    // last dead-time step of the tail, whatever the programmed dead time
    sequence tail_last;
        ce && s.phase == pwm_pkg::PH_TAIL && s.dt_cnt == 5'h00 && !shut_now;
    endsequence

    period_wrap_a: assert property (period_hit |=> tail_entered)
        else $error("period match did not wrap and set the flag");

    idle_rest_a: assert property (s.phase == pwm_pkg::PH_IDLE |=> ##1
        (!s.hs_act && !s.ls_act && !s.sb_act) || s.phase != pwm_pkg::PH_IDLE)
        else $error("output active while the timer is idle");

    low_follows_a: assert property ($rose(s.ls_act) |-> s.hs_act)
        else $error("low side went active before high side");

    high_trails_a: assert property ($fell(s.hs_act) |-> !s.ls_act)
        else $error("high side rested while low side active");

    no_sw_set_a: assert property (wr_ctrl && !s.pend && !pend_evt |=> !s.pend)
        else $error("software write set the pending flag");

    polarity_pin_a: assert property (ce |=> pins.high_side_out ==
        ($past(s.hs_act & hs_en) ^ $past(s.pdata[pwm_pkg::HS_POL])))
        else $error("high side pin polarity wrong");

    irq_source_a: assert property (ce |=> timer_irq ==
        $past(s.irq_en & (s.pend | (capture & s.ovf))))
        else $error("interrupt request does not follow the flags");

    strobe_route_a: assert property (ce |=> pins.converter_strobe_oe ==
        $past(s.pcfg[pwm_pkg::SB_POL] & s.route))
        else $error("strobe pin enable ignores routing bit");

    capture_copy_a: assert property (ce && tick && capture && cap_edge
        && s.phase == pwm_pkg::PH_RUN |=> s.pend && s.period == $past(s.cnt))
        else $error("capture edge did not copy the counter");

    tail_length_a: assert property (tail_last |=>
        s.phase != pwm_pkg::PH_TAIL && !s.hs_act)
        else $error("cycle did not end after the dead time");

    // a comparator trip must win over the dead-time follow-up of the low side
    shut_rest_a: assert property (ce && shut_now |=> !s.hs_act && !s.ls_act)
        else $error("bridge output active during comparator shutdown");

    // free-running capture count wraps at the top and flags it
    overflow_wrap_a: assert property (ce && tick && capture
        && s.phase == pwm_pkg::PH_RUN && s.cnt == pwm_pkg::CNT_MAX
        |=> s.cnt == pwm_pkg::CNT_ZERO && s.ovf)
        else $error("capture counter did not wrap with overflow");

    // conversion kick follows the strobe's rest-to-active edge
    conv_kick_a: assert property (ce && n.sb_act && !s.sb_act
        && s.conv[pwm_pkg::AUTO_BIT] |=> converter_start)
        else $error("strobe edge did not start a conversion");

endmodule : pwm_timer_dead_time_capture

`default_nettype wire

// ---- hdl/pwm_pkg.sv ----
// pwm_pkg: register map, field positions, counts and carrier types of
// the dead-time pwm / capture timer.
// assumes a 32-bit apb slave with 8 address bits and a single clock.
package pwm_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL     = 8'h00; // timer_control_reg
    localparam logic [7:0] OFF_PERIOD   = 8'h04; // period_capture_reg
    localparam logic [7:0] OFF_CMPA     = 8'h08; // compare_a_reg
    localparam logic [7:0] OFF_CMPB     = 8'h0c; // compare_b_reg
    localparam logic [7:0] OFF_DEAD     = 8'h10; // dead_time_reg
    localparam logic [7:0] OFF_PRESCALE = 8'h14; // prescale_reg
    localparam logic [7:0] OFF_PDATA    = 8'h18; // port_data_reg
    localparam logic [7:0] OFF_PCFG     = 8'h1c; // port_config_reg
    localparam logic [7:0] OFF_CONV     = 8'h20; // converter_control_reg
    localparam logic [7:0] OFF_SHUT     = 8'h24; // shutdown_ctrl_reg
    localparam logic [7:0] OFF_COUNT    = 8'h28; // timer_counter readback

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_LSB  = 5; // mode_bit_one..mode_bit_three
    localparam int RUN_BIT   = 4; // run_or_overflow_bit
    localparam int PEND_BIT  = 3; // period_pending_flag
    localparam int IRQEN_BIT = 2; // timer_irq_enable
    localparam int ROUTE_BIT = 0; // strobe_route_bit
    localparam int HS_POL    = 0; // port data / config bit of high side
    localparam int SB_POL    = 1; // port data / config bit of strobe
    localparam int LS_POL    = 5; // port data / config bit of low side
    localparam int AUTO_BIT  = 0; // auto_strobe_enable
    localparam int SHUT_EN   = 0; // shutdown acts on the outputs
    localparam int SHUT_ALL  = 1; // shutdown stops the whole timer

    // ------------------------------------------------------------
    // counts and reset values
    // ------------------------------------------------------------
    localparam logic [11:0] CNT_ZERO  = 12'h000;
    localparam logic [11:0] CNT_MAX   = 12'hfff;
    localparam logic [1:0]  INIT_LOAD = 2'h2; // synchroniser depth
    localparam logic [1:0]  INIT_DONE = 2'h3;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_TAIL} phase_t;

    // pins toward the gate driver
    typedef struct packed {
        logic high_side_out;
        logic high_side_oe;
        logic low_side_out;
        logic low_side_oe;
        logic converter_strobe;
        logic converter_strobe_oe;
    } bridge_pins_t;

    // whole state of the timer
    typedef struct packed {
        logic [6:0]   div_cnt;
        logic [11:0]  cnt;
        logic [11:0]  period;
        logic [11:0]  cmpa;
        logic [11:0]  cmpb;
        logic [4:0]   dead;
        logic [7:0]   prescale;
        logic [7:0]   pdata;
        logic [7:0]   pcfg;
        logic [7:0]   conv;
        logic [1:0]   shut;
        logic [2:0]   mode;
        logic         run_req;
        logic         run_act;
        logic         ovf;
        logic         pend;
        logic         irq_en;
        logic         route;
        phase_t       phase;
        logic [4:0]   dt_cnt;
        logic         lead_pend;
        logic         hs_act;
        logic         ls_act;
        logic         sb_act;
        logic         killed;
        logic         cap_prev;
        logic [4:0]   sync1;
        logic [4:0]   sync2;
        logic [1:0]   init_cnt;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
        bridge_pins_t pins;
        logic         conv_start;
        logic         irq;
    } timer_state_t;

endpackage : pwm_pkg

// ---- testbench/bridge_side_model.sv ----
// bridge_side_model: gate driver and capture source at the timer pins.
// assumes the pins arrive straight from the timer on the bench clock.
`timescale 1ns/1ns
`default_nettype none
module bridge_side_model (
    // clock, reset, pins
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire pwm_pkg::bridge_pins_t pins,
    input  wire logic                  src_level,
    input  wire logic                  armed,
    // resolved low side wire and sticky fault
    output logic                       ls_wire,
    output logic                       order_fault
);
    // timer owns the shared wire while enabled, else the source drives it
    assign ls_wire = pins.low_side_oe ? pins.low_side_out : src_level;
    // low leg on while high leg is off would break the bridge sequencing;
    // watched only once the bench has made both legs active high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            order_fault <= 1'b0;
        end else if (armed & pins.low_side_out & ~pins.high_side_out) begin
            order_fault <= 1'b1;
        end
    end
endmodule : bridge_side_model
`default_nettype wire

// ---- testbench/pwm_timer_dead_time_capture_tb.sv ----
// pwm_timer_dead_time_capture_tb: apb sequences for pwm, dead time, flags, capture.
// assumes one apb wait state and ce held high throughout.
`timescale 1ns/1ns
`default_nettype none
module pwm_timer_dead_time_capture_tb;
    logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic                  converter_start, timer_irq, src_level, ls_wire, order_fault;
    logic                  armed, shut;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, rd;
    pwm_pkg::bridge_pins_t pins;
    int                    miscompares, comparisons, cycles, starts;

    pwm_timer_dead_time_capture pwm_timer_dead_time_capture_i (.pclk(pclk),
        .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_side_out_capture_in(ls_wire), .init_polarity(2'h2),
        .init_output(2'h3), .comparator_shutdown(shut), .pins(pins),
        .converter_start(converter_start), .timer_irq(timer_irq));
    bridge_side_model bridge_side_model_i (.pclk(pclk), .presetn(presetn), .pins(pins),
        .src_level(src_level), .armed(armed), .ls_wire(ls_wire),
        .order_fault(order_fault));

    // ------------------------------------------------------------
    // clock, hang guard, event count
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // a stuck handshake would otherwise spin the polls forever
    always @(posedge pclk) begin
        cycles++;
        if (converter_start === 1'b1) starts++;
        if (cycles == 30000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic poll(input int b, input logic v);
        do apb(1'b0, pwm_pkg::OFF_CTRL, 32'h0); while (rd[b] !== v);
    endtask : poll
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, src_level, armed, shut} = 7'h0;
        {paddr, pwdata, miscompares, comparisons, cycles, starts} = '0;
        repeat (16) @(posedge pclk);
        check(32'(pins), 32'h0);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, pwm_pkg::OFF_PDATA, 32'h0);
        check(rd, 32'h20);
        apb(1'b0, pwm_pkg::OFF_PCFG, 32'h0);
        check(rd, 32'h21);
        // pins become outputs before the counter starts
        apb(1'b1, pwm_pkg::OFF_PDATA, 32'h0);
        apb(1'b1, pwm_pkg::OFF_PCFG, 32'h23);
        apb(1'b1, pwm_pkg::OFF_PERIOD, 32'h5);
        apb(1'b1, pwm_pkg::OFF_CMPA, 32'h1);
        apb(1'b1, pwm_pkg::OFF_CMPB, 32'h2);
        apb(1'b1, pwm_pkg::OFF_DEAD, 32'h1);
        apb(1'b1, pwm_pkg::OFF_CONV, 32'h1);
        // legs are active high from here, so the order watch may start
        armed <= 1'b1;
        apb(1'b1, pwm_pkg::OFF_CTRL, 32'h75);
        wait (pins.high_side_out === 1'b1);
        check(32'(pins.low_side_out), 32'h0);
        wait (pins.low_side_out === 1'b1);
        check(32'(pins.high_side_out), 32'h1);
        wait (pins.low_side_out === 1'b0);
        check(32'(pins.high_side_out), 32'h1);
        poll(pwm_pkg::PEND_BIT, 1'b1);
        check(32'(timer_irq), 32'h1);
        check(32'(starts > 0), 32'h1);
        // comparator trip holds both legs at rest while the timer runs on
        apb(1'b1, pwm_pkg::OFF_SHUT, 32'h1);
        shut <= 1'b1;
        repeat (3) @(posedge pclk);
        check(32'(pins.high_side_out | pins.low_side_out), 32'h0);
        shut <= 1'b0;
        // stop with pend written 1: cycle finishes, flag holds
        apb(1'b1, pwm_pkg::OFF_CTRL, 32'h6d);
        poll(pwm_pkg::RUN_BIT, 1'b0);
        check(32'(rd[3]), 32'h1);
        apb(1'b1, pwm_pkg::OFF_CTRL, 32'h64);
        apb(1'b0, pwm_pkg::OFF_CTRL, 32'h0);
        check(rd, 32'h64);
        check(32'(timer_irq), 32'h0);
        check(32'(order_fault), 32'h0);
        apb(1'b0, pwm_pkg::OFF_COUNT, 32'h0);
        check(rd, 32'h0);
        // capture on a rising edge, then a free-running overflow
        apb(1'b1, pwm_pkg::OFF_PCFG, 32'h03);
        apb(1'b1, pwm_pkg::OFF_CTRL, 32'h84);
        src_level <= 1'b1;
        poll(pwm_pkg::PEND_BIT, 1'b1);
        check(32'(timer_irq), 32'h1);
        apb(1'b0, pwm_pkg::OFF_PERIOD, 32'h0);
        check(32'(rd[11:0] != 12'h0), 32'h1);
        // clear both flags; only the overflow may raise the request again
        apb(1'b1, pwm_pkg::OFF_CTRL, 32'h84);
        poll(pwm_pkg::RUN_BIT, 1'b1);
        check(32'(rd[3]), 32'h0);
        check(32'(timer_irq), 32'h1);
        apb(1'b0, 8'hfc, 32'h0);
        check({rd[30:0], err}, 32'h1);
        final_report();
    end
endmodule : pwm_timer_dead_time_capture_tb
`default_nettype wire
